// >>> design/spr_pkg.sv
// shared constants and state types for the serial port readback block
package spr_pkg;

  // ----------------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------------
  localparam int SPR_ADDR_W = 7;
  localparam int SPR_DATA_W = 8;
  localparam logic [4:0] SPR_CNT_FIRST = 5'h00;
  localparam logic [4:0] SPR_CNT_LAST_HDR = 5'h07;
  localparam logic [4:0] SPR_CNT_FIRST_DATA = 5'h08;
  localparam logic [4:0] SPR_CNT_LAST_DATA = 5'h0f;
  localparam logic [4:0] SPR_CNT_DONE = 5'h10;
  localparam logic [4:0] SPR_CNT_STEP = 5'h01;
  localparam logic SPR_RW_READ = 1'b1;

  // ----------------------------------------------------------------------
  // configuration register
  // ----------------------------------------------------------------------
  localparam logic [6:0] SPR_CFG_ADDR = 7'h00;
  localparam int SPR_CFG_FOUR_WIRE_BIT = 0;
  localparam logic [7:0] SPR_REG_RESET = 8'h00;
  localparam logic SPR_FOUR_WIRE_RESET = 1'b0;

  // ----------------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [4:0] cnt;
    logic [6:0] shift;
    logic is_read;
    logic [6:0] addr;
  } spr_frame_type;

  typedef struct packed {
    logic four_wire;
    logic wr_toggle;
  } spr_cfg_type;

  typedef struct packed {
    logic drive;
    logic data;
  } spr_out_type;

  typedef struct packed {
    logic ce_s1;
    logic ce_s2;
    logic power_down;
    logic mode_s1;
    logic mode_s2;
    logic wt_s1;
    logic wt_s2;
    logic wt_s3;
    logic done;
  } spr_sys_type;

endpackage

// >>> design/spr_reg_mem.sv
// register storage of the serial port with registered read data
`timescale 1ns/1ps
module spr_reg_mem
  import spr_pkg::*;
#(
  parameter int ADDR_W = SPR_ADDR_W,
  parameter int DATA_W = SPR_DATA_W,
  parameter logic [DATA_W-1:0] RESET_VAL = SPR_REG_RESET
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wr_en_in,
  input wire logic [ADDR_W-1:0] wr_addr_in,
  input wire logic [DATA_W-1:0] wr_data_in,
  input wire logic rd_en_in,
  input wire logic [ADDR_W-1:0] rd_addr_in,
  output logic [DATA_W-1:0] rd_data_out
);

  localparam int DEPTH = 1 << ADDR_W;

  typedef struct packed {
    logic [DEPTH-1:0][DATA_W-1:0] mem;
    logic [DATA_W-1:0] rdata;
  } spr_mem_type;

  spr_mem_type st;
  spr_mem_type next_st;

  // ----------------------------------------------------------------------
  // access
  // ----------------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (wr_en_in) begin
      next_st.mem[wr_addr_in] = wr_data_in;
    end
    if (rd_en_in) begin
      next_st.rdata = st.mem[rd_addr_in];
    end
  end

  // clear of every word keeps the map defined after power-down
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st <= '{mem: {DEPTH{RESET_VAL}}, rdata: RESET_VAL};
    end else begin
      st <= next_st;
    end
  end

  assign rd_data_out = st.rdata;

endmodule

// >>> design/spr_serial_port.sv
// serial configuration port with three- and four-wire readback
`timescale 1ns/1ps
module spr_serial_port
  import spr_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic chip_enable_in,
  input wire logic port_select_n_in,
  input wire logic serial_clock_in,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe_out,
  output logic aux_serial_output_out,
  output logic aux_serial_output_oe_out,
  output logic power_down_out,
  output logic four_wire_mode_out,
  output logic write_done_out
);

  spr_frame_type lk;
  spr_frame_type next_lk;
  spr_cfg_type cf;
  spr_cfg_type next_cf;
  spr_out_type ng;
  spr_out_type next_ng;
  spr_sys_type sy;
  spr_sys_type next_sy;

  logic link_rst;
  logic frame_rst;
  logic [6:0] shift_in;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic mem_we;
  logic mem_re;
  logic [2:0] bit_idx;

  // ----------------------------------------------------------------------
  // frame decoding shared by several paths
  // ----------------------------------------------------------------------
  // edge position test for the field boundaries
  function automatic logic at_edge(input logic [4:0] cnt,
      input logic [4:0] pos);
    return cnt == pos;
  endfunction

  // from the first data edge of a read frame on
  function automatic logic read_phase(input spr_frame_type f);
    return f.is_read && (f.cnt >= SPR_CNT_FIRST_DATA);
  endfunction

  // a data bit is still to be launched
  function automatic logic bit_due(input spr_frame_type f);
    return read_phase(f) && (f.cnt <= SPR_CNT_LAST_DATA);
  endfunction

  // ----------------------------------------------------------------------
  // resets of the link side
  // ----------------------------------------------------------------------
  // power-down clears configuration
  assign link_rst = rst_in | sy.power_down;
  assign frame_rst = link_rst | port_select_n_in;

  // ----------------------------------------------------------------------
  // frame receiver, serial clock rising edge
  // ----------------------------------------------------------------------
  assign shift_in = {lk.shift[5:0], sdio_in};
  assign wr_data = {lk.shift, sdio_in};

  always_comb begin
    next_lk = lk;
    mem_we = 1'b0;
    mem_re = 1'b0;
    next_lk.shift = shift_in;
    if (!at_edge(lk.cnt, SPR_CNT_DONE)) begin
      next_lk.cnt = lk.cnt + SPR_CNT_STEP;
    end
    if (at_edge(lk.cnt, SPR_CNT_FIRST)) begin
      next_lk.is_read = (sdio_in == SPR_RW_READ);
    end
    if (at_edge(lk.cnt, SPR_CNT_LAST_HDR)) begin
      next_lk.addr = shift_in;
      mem_re = lk.is_read;
    end
    if (at_edge(lk.cnt, SPR_CNT_LAST_DATA) && !lk.is_read) begin
      mem_we = 1'b1;
    end
  end

  // a select pulse resets the frame; sclk may stop outside frames
  always_ff @(posedge serial_clock_in or posedge frame_rst) begin
    if (frame_rst) begin
      lk <= '0;
    end else begin
      lk <= next_lk;
    end
  end

  // ----------------------------------------------------------------------
  // configuration, survives the end of a frame
  // ----------------------------------------------------------------------
  always_comb begin
    next_cf = cf;
    if (mem_we) begin
      next_cf.wr_toggle = ~cf.wr_toggle;
      if (lk.addr == SPR_CFG_ADDR) begin
        next_cf.four_wire = wr_data[SPR_CFG_FOUR_WIRE_BIT];
      end
    end
  end

  always_ff @(posedge serial_clock_in or posedge link_rst) begin
    if (link_rst) begin
      cf <= '{
        four_wire: SPR_FOUR_WIRE_RESET,
        wr_toggle: 1'b0
      };
    end else begin
      cf <= next_cf;
    end
  end

  spr_reg_mem #(
    .ADDR_W(SPR_ADDR_W),
    .DATA_W(SPR_DATA_W),
    .RESET_VAL(SPR_REG_RESET)
  ) u_mem (
    .clk_in(serial_clock_in),
    .rst_in(link_rst),
    .wr_en_in(mem_we),
    .wr_addr_in(lk.addr),
    .wr_data_in(wr_data),
    .rd_en_in(mem_re),
    .rd_addr_in(shift_in),
    .rd_data_out(rd_data)
  );

  // ----------------------------------------------------------------------
  // read data driver, serial clock falling edge
  // ----------------------------------------------------------------------
  // launching on the falling edge gives the host a half period of hold
  assign bit_idx = 3'(SPR_CNT_LAST_DATA - lk.cnt);

  always_comb begin
    next_ng = ng;
    next_ng.drive = read_phase(lk);
    if (bit_due(lk)) begin
      next_ng.data = rd_data[bit_idx];
    end
  end

  // select high releases the pins at once
  always_ff @(negedge serial_clock_in or posedge frame_rst) begin
    if (frame_rst) begin
      ng <= '0;
    end else begin
      ng <= next_ng;
    end
  end

  // ----------------------------------------------------------------------
  // pin steering
  // ----------------------------------------------------------------------
  // three-wire read on data pin
  assign sdio_oe_out = ng.drive & ~cf.four_wire;
  assign sdio_out = ng.data;
  // aux pin only in four-wire mode
  assign aux_serial_output_oe_out = ng.drive & cf.four_wire;
  assign aux_serial_output_out = ng.data;

  // ----------------------------------------------------------------------
  // system clock side: chip enable, mode and write status
  // ----------------------------------------------------------------------
  always_comb begin
    next_sy = sy;
    next_sy.ce_s1 = chip_enable_in;
    next_sy.ce_s2 = sy.ce_s1;
    next_sy.power_down = ~sy.ce_s2;
    // mode is a slow level, two flops suffice
    next_sy.mode_s1 = cf.four_wire;
    next_sy.mode_s2 = sy.mode_s1;
    // writes cross as a toggle, so a frame
    // shorter than a clock period is not lost
    next_sy.wt_s1 = cf.wr_toggle;
    next_sy.wt_s2 = sy.wt_s1;
    next_sy.wt_s3 = sy.wt_s2;
    next_sy.done = sy.wt_s3 ^ sy.wt_s2;
    // power-down clears the toggle; that is no write
    if (sy.power_down) begin
      next_sy.wt_s1 = 1'b0;
      next_sy.wt_s2 = 1'b0;
      next_sy.wt_s3 = 1'b0;
      next_sy.done = 1'b0;
    end
  end

  // device starts powered down until the enable has been seen high
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sy <= '{
        ce_s1: 1'b0,
        ce_s2: 1'b0,
        power_down: 1'b1,
        mode_s1: SPR_FOUR_WIRE_RESET,
        mode_s2: SPR_FOUR_WIRE_RESET,
        wt_s1: 1'b0,
        wt_s2: 1'b0,
        wt_s3: 1'b0,
        done: 1'b0
      };
    end else begin
      sy <= next_sy;
    end
  end

  assign power_down_out = sy.power_down;
  assign four_wire_mode_out = sy.mode_s2;
  assign write_done_out = sy.done;

endmodule

// >>> test/spr_serial_port_checker.sv
// assertion checker for the serial port readback block
`timescale 1ns/1ps
module spr_serial_port_checker (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic chip_enable_in,
  input wire logic port_select_n_in,
  input wire logic serial_clock_in,
  input wire logic sdio_in,
  input wire logic sdio_oe_out,
  input wire logic aux_serial_output_oe_out,
  input wire logic power_down_out,
  input wire logic four_wire_mode_out
);
  logic [4:0] cnt;
  logic rd;
  logic oe;
  logic fw;
  assign oe = sdio_oe_out | aux_serial_output_oe_out;
  assign fw = four_wire_mode_out;
  always_ff @(posedge serial_clock_in or posedge port_select_n_in) begin
    if (port_select_n_in) begin
      cnt <= 5'h00;
      rd <= 1'b0;
    end else begin
      if (cnt < 5'h10) cnt <= cnt + 5'h01;
      if (cnt == 5'h00) rd <= sdio_in;
    end
  end
  sequence ce_low_s;
    !chip_enable_in [*3];
  endsequence
  // ---
  // checks
  // ---
  quiet_header_a: assert property (@(negedge serial_clock_in)
    disable iff (power_down_out) cnt <= 5'h08 |-> !oe)
    else $error("drive in header");
  write_quiet_a: assert property (@(negedge serial_clock_in)
    disable iff (power_down_out) (!rd && cnt != 5'h00) |-> !oe)
    else $error("drive in write");
  read_three_a: assert property (@(negedge serial_clock_in)
    disable iff (power_down_out) (rd && cnt > 5'h08 && !fw)
    |-> sdio_oe_out && !aux_serial_output_oe_out) else $error("3w read");
  read_four_a: assert property (@(negedge serial_clock_in)
    disable iff (power_down_out) (rd && cnt > 5'h08 && fw)
    |-> aux_serial_output_oe_out && !sdio_oe_out) else $error("4w read");
  aux_idle_a: assert property (@(posedge clk_in)
    disable iff (rst_in) !fw |-> !aux_serial_output_oe_out)
    else $error("aux driven");
  deselect_hiz_a: assert property (@(posedge clk_in)
    disable iff (rst_in) port_select_n_in |-> !oe)
    else $error("drive after deselect");
  ce_down_a: assert property (@(posedge clk_in)
    disable iff (rst_in) ce_low_s |=> power_down_out)
    else $error("no power down");
  mode_clear_a: assert property (@(posedge clk_in)
    disable iff (rst_in) power_down_out [*4] |-> !fw)
    else $error("mode kept");
endmodule

bind spr_serial_port spr_serial_port_checker chk_i (
  .clk_in(clk_in), .rst_in(rst_in), .chip_enable_in(chip_enable_in),
  .port_select_n_in(port_select_n_in), .serial_clock_in(serial_clock_in),
  .sdio_in(sdio_in), .sdio_oe_out(sdio_oe_out),
  .aux_serial_output_oe_out(aux_serial_output_oe_out),
  .power_down_out(power_down_out), .four_wire_mode_out(four_wire_mode_out)
);

// >>> test/spr_host_model.sv
// host serial master model for the configuration port
`timescale 1ns/1ps
module spr_host_model (
  output logic sel_n_out,
  output logic sclk_out,
  output logic sdo_out,
  input wire logic sdio_line_in,
  input wire logic aux_line_in
);
  initial begin
    sel_n_out = 1'b1;
    sclk_out = 1'b0;
    sdo_out = 1'b0;
  end
  // clock stands still between frames
  task automatic xfer(input logic [15:0] w, input logic four,
                      input int hp, output logic [7:0] q);
    sel_n_out = 1'b0;
    #(hp);
    for (int i = 15; i >= 0; i--) begin
      sdo_out = (w[15] && i < 8) ? !sdo_out : w[i];
      #(hp);
      sclk_out = 1'b1;
      if (i < 8) q[i] = four ? aux_line_in : sdio_line_in;
      #(hp);
      sclk_out = 1'b0;
    end
    #(hp);
    sel_n_out = 1'b1;
    sdo_out = !sdo_out;
    #(2 * hp);
  endtask
endmodule

// >>> test/testbench.sv
// self-checking testbench for the serial port readback block
`timescale 1ns/1ps
module testbench;
  import spr_pkg::*;
  logic clk_in, rst_in, chip_enable_in, sel_n, sclk, host_d;
  logic sdio_out, sdio_oe, aux_out, aux_oe, pd, fw, wdone;
  logic sdio_line, aux_line;
  logic [7:0] q;
  int errors, num_checks, cyc;
  // no pull on the aux pin: released aux line reads inverted; released data line carries the host bit
  assign sdio_line = sdio_oe ? sdio_out : host_d;
  assign aux_line = aux_oe ? aux_out : !aux_out;
  spr_serial_port uut (
    .clk_in(clk_in), .rst_in(rst_in), .chip_enable_in(chip_enable_in),
    .port_select_n_in(sel_n), .serial_clock_in(sclk), .sdio_in(sdio_line),
    .sdio_out(sdio_out), .sdio_oe_out(sdio_oe),
    .aux_serial_output_out(aux_out), .aux_serial_output_oe_out(aux_oe),
    .power_down_out(pd), .four_wire_mode_out(fw), .write_done_out(wdone));
  spr_host_model host (
    .sel_n_out(sel_n), .sclk_out(sclk), .sdo_out(host_d),
    .sdio_line_in(sdio_line), .aux_line_in(aux_line));
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = !clk_in;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    logic seen;
    seen = 1'b0;
    host.xfer({1'b0, a, d}, 1'b0, 3, q);
    repeat (8) begin
      @(posedge clk_in);
      #1;
      seen = seen | wdone;
    end
    chk({7'h00, seen}, 8'h01);
  endtask
  task automatic rd_reg(input logic [6:0] a, input logic four,
                        input int hp, input logic [7:0] exp);
    host.xfer({1'b1, a, 8'h00}, four, hp, q);
    chk(q, exp);
  endtask
  task automatic t_three_wire();
    chk({7'h00, fw}, 8'h00);
    rd_reg(SPR_CFG_ADDR, 1'b0, 3, SPR_REG_RESET);
    wr_reg(7'h55, 8'ha5);
    wr_reg(7'h7f, 8'h3c);
    rd_reg(7'h55, 1'b0, 3, 8'ha5);
    rd_reg(7'h7f, 1'b0, 9, 8'h3c);
  endtask
  task automatic t_four_wire();
    wr_reg(SPR_CFG_ADDR, 8'h01);
    chk({7'h00, fw}, 8'h01);
    rd_reg(7'h55, 1'b1, 9, 8'ha5);
    rd_reg(SPR_CFG_ADDR, 1'b1, 3, 8'h01);
  endtask
  task automatic t_chip_enable();
    logic seen;
    seen = 1'b0;
    @(posedge clk_in);
    #1;
    chip_enable_in = 1'b0;
    repeat (5) begin
      @(posedge clk_in);
      #1;
      seen = seen | wdone;
    end
    chk({7'h00, pd}, 8'h01);
    chk({7'h00, fw}, 8'h00);
    chip_enable_in = 1'b1;
    repeat (6) begin
      @(posedge clk_in);
      #1;
      seen = seen | wdone;
    end
    chk({7'h00, seen}, 8'h00);
    rd_reg(7'h55, 1'b0, 3, SPR_REG_RESET);
  endtask
  initial begin
    rst_in = 1'b1;
    chip_enable_in = 1'b1;
    repeat (6) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    repeat (6) @(posedge clk_in);
    #1;
    t_three_wire();
    t_four_wire();
    t_chip_enable();
    wrap_up();
  end
  // whole run needs well under 200 cycles
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
endmodule
